// ### core/setpoint_ramp_programmer.sv
// setpoint ramp programmer: ten-segment ramp/dwell sequencer with apb regs
// assumes synchronous inputs on i_clk and an apb3 master on the bus
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps

// Function
// [RULE_01] ten targets, program repeats, drives working setpoint
// [RULE_02] first ramp from local setpoint, then target-to-target
// [RULE_03] at finish, last value becomes local setpoint
// [RULE_04] off, on, suspended; suspend freezes, on resumes
// [RULE_05] repeat count 1..250, 250 runs forever
// [RULE_06] count locked while running, shows cycles remaining
// [RULE_07] segment time 0..9999 minutes, default zero
// [RULE_08] zero segment time ends the active sequence
// [RULE_09] equal adjacent targets give a dwell
// [RULE_10] operating level shows working setpoint on display
// [RULE_11] software programs everything before switching on
// [RULE_12] linear ramp, target reached exactly at segment end
module setpoint_ramp_programmer #(
  parameter int MINUTE_CYCLES = ramp_pkg::MINUTE_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [15:0] o_working_sp,
  output logic      [15:0] o_local_sp,
  output logic      [15:0] o_lower_display,
  output logic             o_running
);
  localparam int N = ramp_pkg::NUM_SEG;

  ramp_pkg::seq_state_e state_r;
  logic [15:0] target_r [0:N-1];
  logic [13:0] time_r   [0:N-1];
  logic [7:0]  count_r;
  logic [7:0]  remain_r;
  logic [15:0] local_r;
  logic [15:0] wsp_r;
  logic [15:0] start_r;
  logic [13:0] elapsed_r;
  logic [3:0]  seg_r;
  logic [31:0] tick_cnt_r;
  logic [1:0]  run_r;
  logic        oplvl_r;
  logic        ack_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  // apb: one wait state so read data comes from a flip-flop
  // status and wsp are live views; writes to them are dropped
  wire acc      = i_psel & i_penable;
  wire wr_en    = acc & ack_r & i_pwrite;
  wire [3:0] ix = i_paddr[5:2];
  wire ix_ok    = (ix < 4'(N)) & (i_paddr[1:0] == 2'h0);
  wire hit_ctrl  = (i_paddr == ramp_pkg::ADDR_CTRL);
  wire hit_count = (i_paddr == ramp_pkg::ADDR_COUNT);
  wire hit_local = (i_paddr == ramp_pkg::ADDR_LOCAL);
  wire hit_stat  = (i_paddr == ramp_pkg::ADDR_STATUS);
  wire hit_wsp   = (i_paddr == ramp_pkg::ADDR_WSP);
  wire hit_tgt   = (i_paddr[7:6] == ramp_pkg::REGION_TGT) & ix_ok;
  wire hit_time  = (i_paddr[7:6] == ramp_pkg::REGION_TIME) & ix_ok;
  wire mapped    = hit_ctrl | hit_count | hit_local | hit_stat | hit_wsp
                 | hit_tgt | hit_time;
  wire [3:0] ixs = ix_ok ? ix : 4'h0;

  // clamp written values into their documented spans
  wire [13:0] wtime  = (i_pwdata[31:14] != 18'h0) ? ramp_pkg::TIME_MAX :
                       (i_pwdata[13:0] > ramp_pkg::TIME_MAX) ?
                       ramp_pkg::TIME_MAX : i_pwdata[13:0];
  wire [7:0]  wcount = (i_pwdata[31:8] != 24'h0) ? ramp_pkg::CNT_FOREVER :
                       (i_pwdata[7:0] > ramp_pkg::CNT_FOREVER) ?
                       ramp_pkg::CNT_FOREVER :
                       (i_pwdata[7:0] < ramp_pkg::CNT_MIN) ?
                       ramp_pkg::CNT_MIN : i_pwdata[7:0];

  // sequencer decode
  wire is_idle  = (state_r == ramp_pkg::st_idle);
  wire is_run   = (state_r == ramp_pkg::st_run);
  wire is_hold  = (state_r == ramp_pkg::st_hold);
  wire is_done  = (state_r == ramp_pkg::st_done);
  wire busy     = is_run | is_hold;
  wire want_on  = (run_r == ramp_pkg::RUN_ON);
  wire want_sus = (run_r == ramp_pkg::RUN_SUSP);
  wire forever_mode = (count_r == ramp_pkg::CNT_FOREVER);
  wire [15:0] cur_tgt = target_r[seg_r];
  wire [13:0] cur_time = time_r[seg_r];
  wire last_seg = (seg_r == 4'(N - 1));
  wire [3:0] seg_inc = last_seg ? 4'h0 : seg_r + 4'h1;
  wire tick = (tick_cnt_r == 32'(MINUTE_CYCLES - 1));
  wire [13:0] elapsed_inc = elapsed_r + 14'h1;
  wire start_go = is_idle & want_on;
  wire start_empty = start_go & (time_r[0] == ramp_pkg::TIME_RST);
  // a segment only ends while switched on, so off or suspend never loads
  wire seg_done = is_run & want_on & tick & (elapsed_inc >= cur_time);
  wire cycle_end = seg_done & (last_seg |
                   (time_r[seg_inc] == ramp_pkg::TIME_RST));
  // the last pass ends at its cycle end; the endless count never ends
  wire finish = cycle_end & ~forever_mode & (remain_r == 8'h01);

  // linear interpolation: start + delta * elapsed / time
  wire signed [16:0] delta = $signed({cur_tgt[15], cur_tgt})
                           - $signed({start_r[15], start_r});
  // widen before multiplying: 17-bit delta times 9999 needs 31 bits
  wire signed [31:0] prod  = 32'(delta) * $signed({18'h0, elapsed_r});
  wire signed [31:0] quot  = (cur_time == ramp_pkg::TIME_RST) ? 32'sh0 :
                             prod / $signed({18'h0, cur_time});
  wire [15:0] ramp_sp = (cur_time == ramp_pkg::TIME_RST) ? cur_tgt :
                        start_r + quot[15:0]; // RULE_12

  wire [15:0] wsp_nxt = is_run  ? ramp_sp :
                        is_hold ? wsp_r   : local_r;
  wire [7:0]  count_rd = busy ? remain_r : count_r;
  wire [31:0] status_w = {20'h0, seg_r, 5'h0, is_done, is_hold, is_run};
  wire [31:0] rd_mux =
      hit_ctrl  ? {29'h0, oplvl_r, run_r} :
      hit_count ? {24'h0, count_rd} :
      hit_local ? {16'h0, local_r} :
      hit_stat  ? status_w :
      hit_wsp   ? {16'h0, wsp_r} :
      hit_tgt   ? {16'h0, target_r[ixs]} :
      hit_time  ? {18'h0, time_r[ixs]} : 32'h0;

  assign o_prdata        = prdata_r;
  assign o_pready        = acc & ack_r;
  assign o_pslverr       = acc & ack_r & pslverr_r;
  assign o_working_sp    = wsp_r;
  assign o_local_sp      = local_r;
  assign o_running       = is_run;
  assign o_lower_display = oplvl_r ? wsp_r : local_r; // RULE_10

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ack_r     <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      ack_r <= acc & ~ack_r;
      if (acc & ~ack_r) begin
        prdata_r  <= i_pwrite ? 32'h0 : rd_mux;
        pslverr_r <= ~mapped;
      end
    end
  end

  // program storage; software should fill it before switching on
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < N; i++) begin
        target_r[i] <= ramp_pkg::TARGET_RST;
        time_r[i]   <= ramp_pkg::TIME_RST; // RULE_07
      end
      run_r   <= ramp_pkg::RUN_OFF;
      oplvl_r <= 1'b1;
      count_r <= ramp_pkg::CNT_RST;
    end else if (wr_en) begin
      if (hit_tgt)
        target_r[ixs] <= i_pwdata[15:0]; // RULE_01
      if (hit_time)
        time_r[ixs] <= wtime; // RULE_07
      if (hit_ctrl) begin
        run_r   <= i_pwdata[ramp_pkg::CTRL_RUN_LSB +: 2];
        oplvl_r <= i_pwdata[ramp_pkg::CTRL_OPLVL];
      end
      // refused while the program is active
      if (hit_count & ~busy)
        count_r <= wcount; // RULE_05 RULE_06
    end
  end

  // local setpoint: the hardware load at finish beats a software write
  always_ff @(posedge i_clk) begin
    if (!i_nrst)
      local_r <= ramp_pkg::LOCAL_RST;
    else if (finish)
      local_r <= cur_tgt; // RULE_03
    else if (wr_en & hit_local)
      local_r <= i_pwdata[15:0];
  end

  // minute time base: held while suspended so a resume keeps its place
  // within the minute; cleared only when idle or done
  always_ff @(posedge i_clk) begin
    if (!i_nrst)
      tick_cnt_r <= 32'h0;
    else if (is_run & want_on)
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
    else if (is_idle | is_done)
      tick_cnt_r <= 32'h0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst)
      wsp_r <= ramp_pkg::LOCAL_RST;
    else
      wsp_r <= wsp_nxt; // RULE_04
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r   <= ramp_pkg::st_idle;
      seg_r     <= 4'h0;
      elapsed_r <= 14'h0;
      start_r   <= ramp_pkg::LOCAL_RST;
      remain_r  <= ramp_pkg::CNT_RST;
    end else begin
      unique case (state_r)
        ramp_pkg::st_idle: begin
          if (start_empty) begin
            state_r <= ramp_pkg::st_done; // RULE_08
          end else if (start_go) begin
            state_r   <= ramp_pkg::st_run;
            seg_r     <= 4'h0;
            elapsed_r <= 14'h0;
            start_r   <= local_r; // RULE_02
            remain_r  <= count_r; // RULE_06
          end
        end
        ramp_pkg::st_run: begin
          // off abandons the pass; suspend keeps every counter
          if (!want_on) begin
            state_r <= want_sus ? ramp_pkg::st_hold :
                       ramp_pkg::st_idle; // RULE_04
          end else if (finish) begin
            state_r <= ramp_pkg::st_done; // RULE_03
          end else if (seg_done) begin
            // next segment starts from the target just reached
            start_r   <= cur_tgt; // RULE_02 RULE_09
            elapsed_r <= 14'h0;
            if (cycle_end) begin
              seg_r <= 4'h0; // RULE_08
              if (!forever_mode)
                remain_r <= remain_r - 8'h01; // RULE_05 RULE_06
            end else begin
              seg_r <= seg_inc;
            end
          end else if (tick) begin
            elapsed_r <= elapsed_inc; // RULE_12
          end
        end
        ramp_pkg::st_hold: begin
          if (want_on)
            state_r <= ramp_pkg::st_run; // RULE_04
          else if (!want_sus)
            state_r <= ramp_pkg::st_idle;
        end
        ramp_pkg::st_done: begin
          // stays here while switched on; off or suspend returns it to idle
          if (!want_on)
            state_r <= ramp_pkg::st_idle;
        end
      endcase
    end
  end

  property p_seg_range;
    @(posedge i_clk) disable iff (!i_nrst)
      busy |-> (seg_r < 4'(N));
  endproperty
  a_seg_range: assert property (p_seg_range) // RULE_01
    else $error("segment index out of range");

  property p_start_local;
    @(posedge i_clk) disable iff (!i_nrst)
      (start_go & ~start_empty) |=>
        (is_run && seg_r == 4'h0 && start_r == $past(local_r));
  endproperty
  a_start_local: assert property (p_start_local) // RULE_02
    else $error("first segment did not start from local setpoint");

  property p_finish_load;
    @(posedge i_clk) disable iff (!i_nrst)
      finish |=> (is_done && local_r == $past(cur_tgt)) ##1
        (wsp_r == local_r);
  endproperty
  a_finish_load: assert property (p_finish_load) // RULE_03
    else $error("final value not loaded into local setpoint");

  property p_hold_frozen;
    @(posedge i_clk) disable iff (!i_nrst)
      (is_hold && $past(is_hold)) |-> $stable(wsp_r);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) // RULE_04
    else $error("working setpoint moved while suspended");

  property p_forever;
    @(posedge i_clk) disable iff (!i_nrst)
      (cycle_end & forever_mode & want_on) |=>
        (is_run && remain_r == $past(remain_r) && seg_r == 4'h0);
  endproperty
  a_forever: assert property (p_forever) // RULE_05
    else $error("continuous program stopped or counted down");

  property p_count_locked;
    @(posedge i_clk) disable iff (!i_nrst)
      (wr_en & hit_count & busy) |=> $stable(count_r);
  endproperty
  a_count_locked: assert property (p_count_locked) // RULE_06
    else $error("repeat count changed while running");

  property p_time_span;
    @(posedge i_clk) disable iff (!i_nrst)
      (wr_en & hit_time) |=> (time_r[$past(ixs)] <= ramp_pkg::TIME_MAX);
  endproperty
  a_time_span: assert property (p_time_span) // RULE_07
    else $error("segment time above its span");

  property p_zero_ends;
    @(posedge i_clk) disable iff (!i_nrst)
      (seg_done & ~last_seg & (time_r[seg_inc] == ramp_pkg::TIME_RST))
        |=> (seg_r == 4'h0 || is_done);
  endproperty
  a_zero_ends: assert property (p_zero_ends) // RULE_08
    else $error("sequence ran past a zero segment time");

  property p_dwell;
    @(posedge i_clk) disable iff (!i_nrst)
      (is_run && $past(is_run) && cur_tgt == start_r &&
       $stable(cur_tgt) && $stable(start_r)) |-> (wsp_r == start_r);
  endproperty
  a_dwell: assert property (p_dwell) // RULE_09
    else $error("dwell segment did not hold its value");

  property p_display;
    @(posedge i_clk) disable iff (!i_nrst)
      oplvl_r |-> (o_lower_display == wsp_r);
  endproperty
  a_display: assert property (p_display) // RULE_10
    else $error("display does not show working setpoint");

  property p_reach_target;
    @(posedge i_clk) disable iff (!i_nrst)
      (seg_done & want_on) |-> ##2 (wsp_r == $past(cur_tgt, 2));
  endproperty
  a_reach_target: assert property (p_reach_target) // RULE_12
    else $error("segment end did not land on its target");
endmodule

// ### core/ramp_pkg.sv
// constants, register map and state type of the setpoint ramp programmer
// assumes a 25 MHz system clock and 32-bit apb register access
package ramp_pkg;
  localparam int NUM_SEG  = 10;
  localparam int SP_W     = 16;
  localparam int TIME_W   = 14;
  localparam int CNT_W    = 8;
  localparam int SEG_W    = 4;

  // time base: one segment time unit is one minute
  localparam int CLK_HZ        = 25_000_000;
  localparam int MINUTE_S      = 60;
  localparam int MINUTE_CYCLES = CLK_HZ * MINUTE_S;

  localparam logic [TIME_W-1:0] TIME_MAX    = 14'h270f;
  localparam logic [TIME_W-1:0] TIME_RST    = 14'h0000;
  localparam logic [CNT_W-1:0]  CNT_MIN     = 8'h01;
  localparam logic [CNT_W-1:0]  CNT_FOREVER = 8'hfa;
  localparam logic [CNT_W-1:0]  CNT_RST     = 8'h01;
  localparam logic [SP_W-1:0]   TARGET_RST  = 16'h1388;
  localparam logic [SP_W-1:0]   LOCAL_RST   = 16'h0000;

  // byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_LOCAL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_WSP    = 8'h10;
  localparam logic [1:0] REGION_TGT  = 2'h1;
  localparam logic [1:0] REGION_TIME = 2'h2;

  // control fields
  localparam int CTRL_RUN_LSB = 0;
  localparam int CTRL_OPLVL   = 2;
  localparam logic [1:0] RUN_OFF  = 2'h0;
  localparam logic [1:0] RUN_ON   = 2'h1;
  localparam logic [1:0] RUN_SUSP = 2'h2;

  // status fields
  localparam int STAT_RUNNING = 0;
  localparam int STAT_SUSP    = 1;
  localparam int STAT_DONE    = 2;
  localparam int STAT_SEG_LSB = 8;

  typedef enum logic [1:0] {st_idle, st_run, st_hold, st_done} seq_state_e;
endpackage

// ### dv/pid_loop_model.sv
// control-loop stand-in that consumes the working setpoint
// assumes the setpoint is a registered output on the same clock
`timescale 1ns/100ps
module pid_loop_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_setpoint,
  output logic      [15:0] o_process_value
);
  logic [15:0] err;

  assign err = i_setpoint - o_process_value;

  // first-order plant, closes an eighth of the error each cycle
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_process_value <= 16'h0000;
    end else begin
      o_process_value <= o_process_value + 16'($signed(err) >>> 3);
    end
  end
endmodule

// ### dv/test_setpoint_ramp_programmer.sv
// self-checking bench for the setpoint ramp programmer
// assumes one apb wait state; the minute is shortened to four cycles
`timescale 1ns/100ps
module test_setpoint_ramp_programmer;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } note_s;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [15:0] o_working_sp;
  logic [15:0] o_local_sp;
  logic [15:0] o_lower_display;
  logic        o_running;
  note_s       aq[$];
  note_s       cur;
  logic [15:0] wq[$];
  logic [15:0] seen_wsp = 16'h0000;
  logic [15:0] exp_wsp = 16'h0000;
  logic [15:0] held;
  int          n_fail = 0;
  int          tests_run = 0;
  int          loc, k0, k2, tr, t0v, t2v;

  always #20 i_clk = ~i_clk;

  setpoint_ramp_programmer #(.MINUTE_CYCLES(4)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_working_sp(o_working_sp), .o_local_sp(o_local_sp),
    .o_lower_display(o_lower_display), .o_running(o_running)
  );

  pid_loop_model u_loop (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_setpoint(o_working_sp),
    .o_process_value()
  );

  task check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, m,
           input logic e);
    int n;
    aq.push_back('{d, m, e});
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d), 32'h0, 1'b0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, m);
    apb(1'b0, a, d, m, 1'b0);
  endtask

  // only changes of the working setpoint are visible, so skip repeats
  task push_wsp(input logic [15:0] v);
    if (v !== exp_wsp) begin
      wq.push_back(v);
      exp_wsp = v;
    end
  endtask

  task automatic ramp(input int s, input int t, input int n);
    for (int e = 1; e <= n; e++) push_wsp(16'(s + (t - s) * e / n));
  endtask

  task wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge i_clk);
    while (o_running === 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 3000) n_fail++;
    repeat (4) @(posedge i_clk);
  endtask

  always @(posedge i_clk) begin
    if (psel && penable && o_pready === 1'b1) begin
      cur = aq.pop_front();
      check("prdata", o_prdata & cur.m, cur.d & cur.m);
      check("pslverr", {31'h0, o_pslverr}, {31'h0, cur.e});
    end
    if (i_nrst === 1'b1 && o_working_sp !== seen_wsp) begin
      seen_wsp = o_working_sp;
      if (wq.size() == 0)
        check("wsp_extra", {16'h0, seen_wsp}, {16'h0, exp_wsp});
      else
        check("working_sp", {16'h0, seen_wsp},
              {16'h0, wq.pop_front()});
    end
  end

  initial begin
    repeat (10000) @(posedge i_clk);
    n_fail++;
    final_report;
  end

  initial begin
    void'($urandom(81218));
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(ramp_pkg::ADDR_CTRL, 32'h4, '1);
    rd(ramp_pkg::ADDR_COUNT, 32'h1, '1);
    rd(8'h40, 32'h1388, '1);
    rd(8'h80, 32'h0, '1);
    rd(ramp_pkg::ADDR_STATUS, 32'h0, '1);
    apb(1'b0, 8'hfc, 32'h0, '1, 1'b1);
    wr(8'h80, 10000);
    rd(8'h80, 32'd9999, '1);
    wr(ramp_pkg::ADDR_COUNT, 0);
    rd(ramp_pkg::ADDR_COUNT, 32'd1, '1);
    wr(ramp_pkg::ADDR_COUNT, 300);
    rd(ramp_pkg::ADDR_COUNT, 32'd250, '1);
    // ramp, dwell, ramp, then a zero time; two passes
    loc = $urandom_range(2000);
    k0 = $urandom_range(40, 1);
    k2 = int'($urandom_range(60)) - 30;
    tr = $urandom_range(4, 2);
    t0v = loc + k0 * tr;
    t2v = t0v + k2 * tr;
    push_wsp(16'(loc));
    wr(ramp_pkg::ADDR_LOCAL, loc);
    wr(8'h40, t0v);
    wr(8'h44, t0v);
    wr(8'h48, t2v);
    wr(8'h80, tr);
    wr(8'h84, $urandom_range(4, 2));
    wr(8'h88, tr);
    wr(8'h8c, 0);
    wr(ramp_pkg::ADDR_COUNT, 2);
    for (int p = 0; p < 2; p++) begin
      ramp(p ? t2v : loc, t0v, tr);
      ramp(t0v, t2v, tr);
    end
    wr(ramp_pkg::ADDR_CTRL, 5);
    wr(ramp_pkg::ADDR_COUNT, 5);
    rd(ramp_pkg::ADDR_COUNT, 32'd2, 32'hff);
    rd(ramp_pkg::ADDR_STATUS, 32'h1, 32'h7);
    check("running", {31'h0, o_running}, 32'h1);
    wait_idle;
    rd(ramp_pkg::ADDR_STATUS, 32'h4, 32'h7);
    check("local_sp", {16'h0, o_local_sp}, {16'h0, 16'(t2v)});
    wr(ramp_pkg::ADDR_CTRL, 4);
    // single ramp, suspended part way
    k0 = $urandom_range(30, 1);
    push_wsp(16'h0);
    wr(ramp_pkg::ADDR_LOCAL, 0);
    wr(8'h40, k0 * 6);
    wr(8'h80, 6);
    wr(8'h84, 0);
    wr(ramp_pkg::ADDR_COUNT, 1);
    ramp(0, k0 * 6, 6);
    wr(ramp_pkg::ADDR_CTRL, 5);
    repeat (10) @(posedge i_clk);
    wr(ramp_pkg::ADDR_CTRL, 2);
    repeat (3) @(posedge i_clk);
    held = o_working_sp;
    check("display", {16'h0, o_lower_display}, 32'h0);
    wr(ramp_pkg::ADDR_CTRL, 6);
    @(negedge i_clk);
    check("display", {16'h0, o_lower_display}, {16'h0, held});
    repeat (40) @(posedge i_clk);
    check("frozen_sp", {16'h0, o_working_sp}, {16'h0, held});
    check("running", {31'h0, o_running}, 32'h0);
    rd(ramp_pkg::ADDR_STATUS, 32'h2, 32'h3);
    wr(ramp_pkg::ADDR_CTRL, 5);
    wait_idle;
    check("local_sp", {16'h0, o_local_sp}, 32'(k0 * 6));
    // endless repetition, then switched off
    wr(ramp_pkg::ADDR_CTRL, 4);
    wr(8'h40, 100);
    wr(8'h80, 1);
    wr(ramp_pkg::ADDR_COUNT, 250);
    push_wsp(16'd100);
    wr(ramp_pkg::ADDR_CTRL, 5);
    repeat (60) @(posedge i_clk);
    rd(ramp_pkg::ADDR_COUNT, 32'd250, 32'hff);
    rd(ramp_pkg::ADDR_STATUS, 32'h1, 32'h1);
    push_wsp(16'(k0 * 6));
    wr(ramp_pkg::ADDR_CTRL, 4);
    repeat (4) @(posedge i_clk);
    check("wsp_left", 32'(wq.size()), 32'h0);
    final_report;
  end
endmodule
